// [core/svs_packer.sv]
// Subrate field decode and bit rearrangement for a 'from' half.
// Combinational; the caller supplies the old data memory byte.
`timescale 1ns/10ps
`default_nettype none
`include "svs_regs.svh"
module svs_packer (
  svs_pk_if.pk p
);
  logic [7:0] mask;
  logic [7:0] piece;
  logic [2:0] from_sh;
  logic [2:0] to_sh;
  logic active;

  always_comb begin
    mask = 8'h00;
    from_sh = 3'h0;
    to_sh = 3'h0;
    active = 1'b0;
    if (p.en && !p.bonded) begin
      if (p.sub[`SVS_BF_TYPE]) begin
        mask = `SVS_MASK_BIT;
        from_sh = p.sub[`SVS_BF_FROM];
        to_sh = p.sub[`SVS_BF_TO];
        active = 1'b1;
      end else if (p.sub[`SVS_DF_TYPE] == `SVS_TYPE_DI) begin
        mask = `SVS_MASK_DI;
        from_sh = {p.sub[`SVS_DF_FROM], 1'b0};
        to_sh = {p.sub[`SVS_DF_TO], 1'b0};
        active = 1'b1;
      end else if (p.sub[`SVS_NF_TYPE] == `SVS_TYPE_NIB) begin
        mask = `SVS_MASK_NIB;
        from_sh = {p.sub[`SVS_NF_FROM], 2'h0};
        to_sh = {p.sub[`SVS_NF_TO], 2'h0};
        active = 1'b1;
      end
    end
    piece = (p.in_byte >> from_sh) & mask;
    // Only the destination bits change so several froms can share a byte
    if (active) begin
      p.new_byte = (p.old_byte & ~(mask << to_sh)) | (piece << to_sh);
    end else begin
      p.new_byte = p.in_byte;
    end
  end

  // ==========================================================
  // Checks
  AST_DIBIT_KEEP: assert property (@(posedge p.clk) disable iff (p.rst)
    (p.en && !p.bonded && p.sub[`SVS_DF_TYPE] == `SVS_TYPE_DI) |->
    ((p.new_byte & ~(`SVS_MASK_DI << {p.sub[`SVS_DF_TO], 1'b0})) ==
     (p.old_byte & ~(`SVS_MASK_DI << {p.sub[`SVS_DF_TO], 1'b0}))))
    else $error("di-bit write touched other bits");
  AST_BIT_MOVE: assert property (@(posedge p.clk) disable iff (p.rst)
    (p.en && !p.bonded && p.sub[`SVS_BF_TYPE]) |->
    p.new_byte[p.sub[`SVS_BF_TO]] == p.in_byte[p.sub[`SVS_BF_FROM]])
    else $error("bit subrate moved wrong bit");
  AST_NO_SUB: assert property (@(posedge p.clk) disable iff (p.rst)
    (!p.en || p.bonded) |-> p.new_byte == p.in_byte)
    else $error("subrate applied while disabled or bonded");
endmodule : svs_packer
`default_nettype wire

// [core/svs_top.sv]
// Byte-oriented TDM switch with subrate packing and virtual channels.
// Link clock, frame sync and receive data come from another domain and
// are synchronised here; config ports are on sys_clk.
// Notes on behaviour
// - Subrate output always whole byte per slot
// - Many froms write one shared memory byte
// - To half transmits whole stored byte
// - Di-bit field: type 01, from, x, to
// - Subrate field of to halves ignored
// - Switching datapath handles whole bytes only
// - Channel: connection entry plus channel entry
// - Nonbonded and bonded virtual channels supported
// - Subrate only on nonbonded channels
// - Data memory buffers 512 channels, 4K
// - Push: device writes, other agent reads
// - Pull: device reads, other agent writes
// - Subrate only with global enable set
// - From half rearranges bits before writing
`timescale 1ns/10ps
`default_nettype none
`include "svs_regs.svh"
module svs_top #(
  parameter int SLOTS = `SVS_SLOTS,
  parameter int DMB = `SVS_DM_BYTES,
  parameter int NCH = `SVS_VC_NUM
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic link_clk,
  input wire logic link_fs,
  input wire logic link_rx,
  output logic link_tx,
  output logic link_tx_oe,
  input wire logic subrate_en,
  input wire logic cm_we,
  input wire logic [$clog2(SLOTS)-1:0] cm_slot,
  input wire svs_pkg::svs_cm_s cm_wdata,
  input wire logic vc_we,
  input wire logic [`SVS_VC_IDW-1:0] vc_id,
  input wire svs_pkg::svs_vc_s vc_wdata,
  input wire logic ext_rd_req,
  input wire logic [`SVS_DM_AW-1:0] ext_rd_addr,
  output logic [7:0] ext_rd_data,
  output logic ext_rd_vld,
  input wire logic ext_wr_en,
  input wire logic [`SVS_DM_AW-1:0] ext_wr_addr,
  input wire logic [7:0] ext_wr_data,
  output logic ext_wr_rdy,
  output logic xfer_req,
  output logic [`SVS_VC_IDW-1:0] xfer_id,
  output logic xfer_push
);
  localparam int SW = $clog2(SLOTS);

  function automatic logic [SW-1:0] next_slot(input logic [SW-1:0] s);
    next_slot = (s == SW'(SLOTS - 1)) ? '0 : s + 1'b1;
  endfunction : next_slot

  // ==========================================================
  // Memories
  logic [7:0] dm [DMB];
  svs_pkg::svs_cm_s cm [SLOTS];

  // ==========================================================
  // Link synchronisers, bit order {fs, rx, clk}
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic clk_prev_q;
  logic rise;
  logic fall;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s1_q <= '0;
      s2_q <= '0;
      clk_prev_q <= 1'b0;
    end else begin
      s1_q <= {link_fs, link_rx, link_clk};
      s2_q <= s1_q;
      clk_prev_q <= s2_q[0];
    end
  end

  always_comb begin
    rise = s2_q[0] && !clk_prev_q;
    fall = !s2_q[0] && clk_prev_q;
  end

  // ==========================================================
  // Receive: slot and bit counting, MSB first
  logic [2:0] bit_q, bit_d;
  logic [SW-1:0] slot_q, slot_d;
  logic [6:0] rsh_q, rsh_d;
  logic done_q, done_d;
  logic [7:0] rbyte_q, rbyte_d;
  logic [SW-1:0] dslot_q, dslot_d;

  always_comb begin
    bit_d = bit_q;
    slot_d = slot_q;
    rsh_d = rsh_q;
    done_d = 1'b0;
    rbyte_d = rbyte_q;
    dslot_d = dslot_q;
    if (rise) begin
      rsh_d = {rsh_q[5:0], s2_q[1]};
      if (s2_q[2]) begin
        bit_d = `SVS_BIT_AFTER_FS;
        slot_d = '0;
      end else if (bit_q == `SVS_BIT_LAST) begin
        // A slot is only handed on once all eight bits are in
        done_d = 1'b1;
        rbyte_d = {rsh_q, s2_q[1]};
        dslot_d = slot_q;
        bit_d = `SVS_BIT_FIRST;
        slot_d = next_slot(slot_q);
      end else begin
        bit_d = bit_q + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      bit_q <= `SVS_BIT_FIRST;
      slot_q <= '0;
      rsh_q <= '0;
      done_q <= 1'b0;
      rbyte_q <= '0;
      dslot_q <= '0;
    end else begin
      bit_q <= bit_d;
      slot_q <= slot_d;
      rsh_q <= rsh_d;
      done_q <= done_d;
      rbyte_q <= rbyte_d;
      dslot_q <= dslot_d;
    end
  end

  // ==========================================================
  // Slot processing: SRC writes the from half, DST fetches next to half
  svs_pk_if pk (.clk(sys_clk), .rst(reset));
  svs_vc_if vc (.clk(sys_clk), .rst(reset));

  svs_packer u_packer (.p(pk));
  svs_vchan #(.NCH(NCH)) u_vchan (.v(vc));

  svs_pkg::svs_state_e state_q, state_d;
  svs_pkg::svs_cm_s ent;
  logic [`SVS_DM_AW-1:0] src_addr;
  logic [`SVS_DM_AW-1:0] dst_addr;
  logic byte_mode;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      svs_pkg::ST_IDLE: begin
        if (done_q) begin
          state_d = svs_pkg::ST_SRC;
        end
      end
      svs_pkg::ST_SRC: begin
        state_d = svs_pkg::ST_DST;
      end
      svs_pkg::ST_DST: begin
        state_d = svs_pkg::ST_IDLE;
      end
      default: begin
        state_d = svs_pkg::ST_IDLE;
      end
    endcase
  end

  always_comb begin
    ent = (state_q == svs_pkg::ST_DST) ? cm[next_slot(dslot_q)] : cm[dslot_q];
    vc.id = ent.vc_id;
    src_addr = ent.from_vc ? vc.addr : ent.from_addr;
    dst_addr = ent.to_vc ? vc.addr : ent.to_addr;
    byte_mode = !subrate_en || vc.bonded ||
      (ent.sub[`SVS_NF_TYPE] == `SVS_TYPE_BYTE);
    pk.in_byte = rbyte_q;
    pk.old_byte = dm[src_addr];
    pk.sub = ent.sub;
    pk.en = subrate_en;
    pk.bonded = ent.from_vc && vc.bonded;
    vc.adv = 1'b0;
    // A packed channel byte is only complete at its frame marker
    if (state_q == svs_pkg::ST_SRC) begin
      vc.adv = ent.from_en && ent.from_vc && (ent.svf || byte_mode);
    end else if (state_q == svs_pkg::ST_DST) begin
      vc.adv = ent.to_en && ent.to_vc;
    end
    vc.cfg_we = vc_we;
    vc.cfg_id = vc_id;
    vc.cfg_data = vc_wdata;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_q <= svs_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================
  // Memory writes; the TDM write owns its cycle, ext_wr_rdy is low then
  always_ff @(posedge sys_clk) begin
    if (state_q == svs_pkg::ST_SRC && ent.from_en) begin
      dm[src_addr] <= pk.new_byte;
    end else if (ext_wr_en && ext_wr_rdy) begin
      dm[ext_wr_addr] <= ext_wr_data;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < SLOTS; i++) begin
        cm[i] <= '0;
      end
    end else if (cm_we) begin
      cm[cm_slot] <= cm_wdata;
    end
  end

  // ==========================================================
  // Transmit and external side
  logic [7:0] tx_next_q, tx_next_d;
  logic tx_nxoe_q, tx_nxoe_d;
  logic [7:0] tsh_q, tsh_d;
  logic tx_d;
  logic tx_oe_d;
  logic [7:0] rd_data_d;
  logic wr_rdy_d;

  always_comb begin
    tx_next_d = tx_next_q;
    tx_nxoe_d = tx_nxoe_q;
    if (state_q == svs_pkg::ST_DST) begin
      // Whole byte out; the subrate field of a to half plays no part
      tx_next_d = ent.to_en ? dm[dst_addr] : `SVS_IDLE_BYTE;
      tx_nxoe_d = ent.to_en;
    end
    tx_d = link_tx;
    tx_oe_d = link_tx_oe;
    tsh_d = tsh_q;
    if (fall) begin
      if (bit_q == `SVS_BIT_FIRST) begin
        tx_d = tx_next_q[7];
        tsh_d = {tx_next_q[6:0], 1'b0};
        tx_oe_d = tx_nxoe_q;
      end else begin
        tx_d = tsh_q[7];
        tsh_d = {tsh_q[6:0], 1'b0};
      end
    end
    rd_data_d = ext_rd_req ? dm[ext_rd_addr] : ext_rd_data;
    wr_rdy_d = state_d != svs_pkg::ST_SRC;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      tx_next_q <= `SVS_IDLE_BYTE;
      tx_nxoe_q <= 1'b0;
      tsh_q <= '0;
      link_tx <= 1'b1;
      link_tx_oe <= 1'b0;
      ext_rd_data <= '0;
      ext_rd_vld <= 1'b0;
      ext_wr_rdy <= 1'b0;
      xfer_req <= 1'b0;
      xfer_id <= '0;
      xfer_push <= 1'b0;
    end else begin
      tx_next_q <= tx_next_d;
      tx_nxoe_q <= tx_nxoe_d;
      tsh_q <= tsh_d;
      link_tx <= tx_d;
      link_tx_oe <= tx_oe_d;
      ext_rd_data <= rd_data_d;
      ext_rd_vld <= ext_rd_req;
      ext_wr_rdy <= wr_rdy_d;
      xfer_req <= vc.evt;
      xfer_id <= vc.evt_id;
      xfer_push <= vc.evt_push;
    end
  end

  // ==========================================================
  // Checks
  AST_WHOLE_BYTE: assert property (@(posedge sys_clk) disable iff (reset)
    (fall && bit_q == `SVS_BIT_FIRST) |=>
    (tsh_q == {$past(tx_next_q[6:0]), 1'b0} &&
     link_tx == $past(tx_next_q[7])))
    else $error("slot did not start with a fresh byte");
  AST_SHARED_WRITE: assert property (@(posedge sys_clk) disable iff (reset)
    (state_q == svs_pkg::ST_SRC && ent.from_en) |=>
    dm[$past(src_addr)] == $past(pk.new_byte))
    else $error("from half did not reach data memory");
  AST_TO_WHOLE: assert property (@(posedge sys_clk) disable iff (reset)
    (state_q == svs_pkg::ST_DST && ent.to_en) |=>
    tx_next_q == $past(dm[dst_addr]))
    else $error("to half byte not taken whole");
  AST_SEQ: assert property (@(posedge sys_clk) disable iff (reset)
    (state_q == svs_pkg::ST_IDLE && done_q) |=>
    state_q == svs_pkg::ST_SRC ##1 state_q == svs_pkg::ST_DST
    ##1 state_q == svs_pkg::ST_IDLE)
    else $error("slot processing out of order");
  AST_EXT_READ: assert property (@(posedge sys_clk) disable iff (reset)
    ext_rd_req |=> (ext_rd_vld && ext_rd_data == $past(dm[ext_rd_addr])))
    else $error("external read answer wrong");
  AST_EXT_HOLD: assert property (@(posedge sys_clk) disable iff (reset)
    (state_q == svs_pkg::ST_SRC) |-> !ext_wr_rdy)
    else $error("external write open during TDM write");
  AST_RX_BYTE: assert property (@(posedge sys_clk) disable iff (reset)
    (rise && !s2_q[2] && bit_q == `SVS_BIT_LAST) |=>
    (done_q && rbyte_q[0] == $past(s2_q[1]) ##1 !done_q))
    else $error("received byte not handed on");
endmodule : svs_top
`default_nettype wire

// [core/svs_vchan.sv]
// Virtual channel memory: per-channel data memory window and pointer.
// Assumes the top steps a channel at most once per cycle.
`timescale 1ns/10ps
`default_nettype none
`include "svs_regs.svh"
module svs_vchan #(
  parameter int NCH = `SVS_VC_NUM
) (
  svs_vc_if.vc v
);
  svs_pkg::svs_vc_s vcm [NCH];
  logic [`SVS_VC_IDW-1:0] ptr_q [NCH];
  logic wrap;
  logic evt_d;

  always_comb begin
    v.addr = vcm[v.id].base + `SVS_DM_AW'(ptr_q[v.id]);
    v.bonded = vcm[v.id].bonded;
    v.push = vcm[v.id].push;
    wrap = ptr_q[v.id] == vcm[v.id].depth;
    evt_d = v.adv && wrap && !v.cfg_we;
  end

  // Buffer full (push) or empty (pull) raises a burst request
  always_ff @(posedge v.clk or posedge v.rst) begin
    if (v.rst) begin
      for (int i = 0; i < NCH; i++) begin
        vcm[i] <= '0;
        ptr_q[i] <= '0;
      end
      v.evt <= 1'b0;
      v.evt_id <= '0;
      v.evt_push <= 1'b0;
    end else begin
      if (v.cfg_we) begin
        vcm[v.cfg_id] <= v.cfg_data;
        ptr_q[v.cfg_id] <= '0;
      end else if (v.adv) begin
        ptr_q[v.id] <= wrap ? '0 : ptr_q[v.id] + 1'b1;
      end
      v.evt <= evt_d;
      v.evt_id <= v.id;
      v.evt_push <= vcm[v.id].push;
    end
  end

  // ==========================================================
  // Checks
  AST_VC_STEP: assert property (@(posedge v.clk) disable iff (v.rst)
    (v.adv && !wrap && !v.cfg_we) |=>
    ptr_q[$past(v.id)] == $past(ptr_q[v.id]) + 1)
    else $error("channel pointer did not step");
  AST_VC_FULL: assert property (@(posedge v.clk) disable iff (v.rst)
    (v.adv && wrap && !v.cfg_we) |=> (v.evt && ptr_q[$past(v.id)] == 0))
    else $error("channel wrap missed");
endmodule : svs_vchan
`default_nettype wire

// [pkg/svs_if.sv]
// Internal carriers between the switch top, packer and channel table.
// Assumes svs_pkg is compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "svs_regs.svh"
interface svs_pk_if (input wire logic clk, input wire logic rst);
  logic [7:0] in_byte;
  logic [7:0] old_byte;
  logic [7:0] new_byte;
  logic [`SVS_SUB_W-1:0] sub;
  logic en;
  logic bonded;
  modport req (input clk, rst, new_byte,
    output in_byte, old_byte, sub, en, bonded);
  modport pk (input clk, rst, in_byte, old_byte, sub, en, bonded,
    output new_byte);
endinterface : svs_pk_if

interface svs_vc_if (input wire logic clk, input wire logic rst);
  logic [`SVS_VC_IDW-1:0] id;
  logic adv;
  logic [`SVS_DM_AW-1:0] addr;
  logic bonded;
  logic push;
  logic evt;
  logic [`SVS_VC_IDW-1:0] evt_id;
  logic evt_push;
  logic cfg_we;
  logic [`SVS_VC_IDW-1:0] cfg_id;
  svs_pkg::svs_vc_s cfg_data;
  modport req (input clk, rst, addr, bonded, push, evt, evt_id, evt_push,
    output id, adv, cfg_we, cfg_id, cfg_data);
  modport vc (input clk, rst, id, adv, cfg_we, cfg_id, cfg_data,
    output addr, bonded, push, evt, evt_id, evt_push);
endinterface : svs_vc_if
`default_nettype wire

// [pkg/svs_pkg.sv]
// Types shared by the switch modules.
// Assumes svs_regs.svh is on the include path.
`include "svs_regs.svh"
package svs_pkg;
  // Connection memory entry, one per time slot
  typedef struct packed {
    logic from_en;
    logic from_vc;
    logic svf;
    logic [`SVS_SUB_W-1:0] sub;
    logic [`SVS_DM_AW-1:0] from_addr;
    logic to_en;
    logic to_vc;
    logic [`SVS_DM_AW-1:0] to_addr;
    logic [`SVS_VC_IDW-1:0] vc_id;
  } svs_cm_s;
  // Virtual channel memory entry; depth is the last byte index
  typedef struct packed {
    logic [`SVS_DM_AW-1:0] base;
    logic [`SVS_VC_IDW-1:0] depth;
    logic bonded;
    logic push;
  } svs_vc_s;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_SRC = 3'h2,
    ST_DST = 3'h4
  } svs_state_e;
endpackage : svs_pkg

// [pkg/svs_regs.svh]
// Constants of the subrate and virtual channel switch.
// Included by bare name by the package and every design file.
`ifndef SVS_REGS_SVH
`define SVS_REGS_SVH
`define SVS_DM_BYTES 4096
`define SVS_DM_AW 12
`define SVS_VC_NUM 512
`define SVS_VC_IDW 9
`define SVS_SUB_W 7
`define SVS_SLOTS 32
`define SVS_BIT_LAST 3'h7
`define SVS_BIT_FIRST 3'h0
`define SVS_BIT_AFTER_FS 3'h1
`define SVS_IDLE_BYTE 8'hFF
`define SVS_BF_TYPE 6
`define SVS_BF_FROM 5:3
`define SVS_BF_TO 2:0
`define SVS_DF_TYPE 6:5
`define SVS_DF_FROM 4:3
`define SVS_DF_TO 1:0
`define SVS_NF_TYPE 6:4
`define SVS_NF_FROM 3
`define SVS_NF_TO 0
`define SVS_TYPE_DI 2'b01
`define SVS_TYPE_NIB 3'b001
`define SVS_TYPE_BYTE 3'b000
`define SVS_MASK_BIT 8'h01
`define SVS_MASK_DI 8'h03
`define SVS_MASK_NIB 8'h0F
`endif

// [testbench/svs_tdm_partner.sv]
// TDM link partner: makes bit clock and frame sync, sends one byte per
// slot from rx_b and records the byte and enable seen on every slot.
// Assumes 32 slots of 8 bits, MSB first; the bench owns rx_b.
`timescale 1ns/10ps
`default_nettype none
module svs_tdm_partner (
  input wire logic run,
  input wire logic link_tx,
  input wire logic link_tx_oe,
  output logic link_clk,
  output logic link_fs,
  output logic link_rx
);
  logic [7:0] rx_b [32];
  logic [7:0] tx_b [32];
  logic oe_b [32];
  int frames = 0;
  // ==========================================
  // Frame loop
  // Data changes at the fall and is sampled late in the high phase,
  // well after the design's three-cycle output delay has settled.
  initial begin
    link_clk = 1'h0;
    link_fs = 1'h0;
    link_rx = 1'h1;
    forever begin
      if (!run) @(posedge run);
      for (int s = 0; s < 32; s++) begin
        for (int b = 7; b >= 0; b--) begin
          link_fs = (s == 0 && b == 7);
          link_rx = rx_b[s][b];
          #100 link_clk = 1'h1;
          #90 tx_b[s][b] = link_tx;
          oe_b[s] = link_tx_oe;
          #10 link_clk = 1'h0;
        end
      end
      frames++;
      // Never leave the last bit standing between frames
      link_rx = ~link_rx;
    end
  end
endmodule : svs_tdm_partner
`default_nettype wire

// [testbench/testbench.sv]
// Self-checking bench for the subrate and virtual channel switch.
// Assumes the package, interfaces, design and link partner are compiled.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic sys_clk, reset, run, link_clk, link_fs, link_rx, link_tx;
  logic link_tx_oe, subrate_en, cm_we, vc_we, ext_rd_req, ext_rd_vld;
  logic ext_wr_en, ext_wr_rdy, xfer_req, xfer_push;
  logic [4:0] cm_slot;
  logic [8:0] vc_id, xfer_id;
  logic [8:0] push_id = 9'h1FF;
  logic [8:0] pull_id = 9'h1FF;
  logic [11:0] ext_rd_addr, ext_wr_addr;
  logic [7:0] ext_rd_data, ext_wr_data, got, tx_a;
  svs_pkg::svs_cm_s cm_wdata;
  svs_pkg::svs_vc_s vc_wdata;
  int num_errors = 0;
  int checked = 0;

  initial begin
    sys_clk = 1'h0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  svs_top svs_top_inst (.sys_clk, .reset, .link_clk, .link_fs, .link_rx,
    .link_tx, .link_tx_oe, .subrate_en, .cm_we, .cm_slot, .cm_wdata,
    .vc_we, .vc_id, .vc_wdata, .ext_rd_req, .ext_rd_addr, .ext_rd_data,
    .ext_rd_vld, .ext_wr_en, .ext_wr_addr, .ext_wr_data, .ext_wr_rdy,
    .xfer_req, .xfer_id, .xfer_push);
  svs_tdm_partner svs_tdm_partner_inst (.run, .link_tx, .link_tx_oe,
    .link_clk, .link_fs, .link_rx);

  // Last channel that wrapped in each direction; looked at mid-cycle so
  // the pulse and its id are both settled
  always @(negedge sys_clk) begin
    if (xfer_req === 1'h1) begin
      if (xfer_push) push_id <= xfer_id;
      else pull_id <= xfer_id;
    end
  end

  // ==========================================
  // Reporting
  task automatic final_report;
    $display("Counts: %0d checked, %0d mismatches", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  task automatic hang(input string m);
    num_errors++;
    $display("MISMATCH t=%0t %s", $time, m);
    final_report();
  endtask : hang

  task automatic chk(input logic [8:0] g, input logic [8:0] e,
      input string m);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk

  task automatic chk_slot(input int s, input logic [7:0] e, input logic oe);
    chk({1'h0, svs_tdm_partner_inst.tx_b[s]}, {1'h0, e}, "slot byte");
    chk({8'h00, svs_tdm_partner_inst.oe_b[s]}, {8'h00, oe}, "slot enable");
  endtask : chk_slot

  // ==========================================
  // Drivers
  task automatic wait_frames(input int n);
    int f0;
    int k;
    f0 = svs_tdm_partner_inst.frames;
    for (k = 0; k < 3000 * n; k++) begin
      @(negedge sys_clk);
      if (svs_tdm_partner_inst.frames >= f0 + n) break;
    end
    if (k >= 3000 * n) hang("frame wait timed out");
  endtask : wait_frames

  task automatic cmw(input logic [4:0] s, input svs_pkg::svs_cm_s e);
    @(negedge sys_clk);
    cm_we = 1'h1;
    cm_slot = s;
    cm_wdata = e;
    @(negedge sys_clk);
    cm_we = 1'h0;
  endtask : cmw

  task automatic vcw(input logic [8:0] id, input svs_pkg::svs_vc_s e);
    @(negedge sys_clk);
    vc_we = 1'h1;
    vc_id = id;
    vc_wdata = e;
    @(negedge sys_clk);
    vc_we = 1'h0;
  endtask : vcw

  task automatic clr;
    for (int s = 0; s < 32; s++) cmw(5'(s), '0);
  endtask : clr

  task automatic cfg_from(input logic [4:0] s, input logic [6:0] sb,
      input logic [11:0] a);
    cmw(s, '{from_en: 1'h1, sub: sb, from_addr: a, default: '0});
  endtask : cfg_from

  // The subrate field of a to half is filled with junk on purpose
  task automatic cfg_to(input logic [4:0] s, input logic [11:0] a);
    cmw(s, '{to_en: 1'h1, sub: 7'h7F, to_addr: a, default: '0});
  endtask : cfg_to

  task automatic ext_wr(input logic [11:0] a, input logic [7:0] d);
    int k;
    logic seen;
    @(negedge sys_clk);
    ext_wr_en = 1'h1;
    ext_wr_addr = a;
    ext_wr_data = d;
    // Ready is read settled, before the edge that takes the write
    for (k = 0; k < 8; k++) begin
      seen = ext_wr_rdy;
      @(negedge sys_clk);
      if (seen === 1'h1) break;
    end
    if (k == 8) hang("write not taken");
    ext_wr_en = 1'h0;
    ext_wr_data = ~d;
  endtask : ext_wr

  task automatic ext_rd(input logic [11:0] a, output logic [7:0] d);
    int k;
    @(negedge sys_clk);
    ext_rd_req = 1'h1;
    ext_rd_addr = a;
    @(negedge sys_clk);
    ext_rd_req = 1'h0;
    ext_rd_addr = ~a;
    for (k = 0; k < 4 && ext_rd_vld !== 1'h1; k++) @(negedge sys_clk);
    if (k == 4) hang("read not answered");
    d = ext_rd_data;
  endtask : ext_rd

  // ==========================================
  // Scenarios
  task automatic t_byte;
    clr();
    svs_tdm_partner_inst.rx_b[2] = 8'h96;
    cfg_from(5'h02, 7'h00, 12'h010);
    cfg_to(5'h05, 12'h010);
    wait_frames(3);
    chk_slot(5, 8'h96, 1'h1);
    chk_slot(7, 8'hFF, 1'h0);
    ext_rd(12'h010, got);
    chk({1'h0, got}, 9'h096, "stored byte");
    ext_wr(12'hFFF, 8'h5A);
    ext_rd(12'hFFF, got);
    chk({1'h0, got}, 9'h05A, "top of data memory");
    $display("Test byte switch done");
  endtask : t_byte

  task automatic t_dibit;
    clr();
    subrate_en = 1'h1;
    ext_wr(12'h020, 8'hFF);
    svs_tdm_partner_inst.rx_b[1] = 8'hC1;
    svs_tdm_partner_inst.rx_b[3] = 8'h0C;
    svs_tdm_partner_inst.rx_b[4] = 8'h20;
    // One piece per incoming slot; bits 3:2 keep the primed value
    cfg_from(5'h01, 7'h23, 12'h020);
    cfg_from(5'h03, 7'h28, 12'h020);
    cfg_from(5'h04, 7'h32, 12'h020);
    cfg_to(5'h0A, 12'h020);
    wait_frames(3);
    chk_slot(10, 8'h6F, 1'h1);
    $display("Test di-bit packing done");
  endtask : t_dibit

  task automatic t_off;
    subrate_en = 1'h0;
    wait_frames(3);
    chk_slot(10, 8'h20, 1'h1);
    $display("Test subrate disabled done");
  endtask : t_off

  task automatic t_vchan;
    clr();
    svs_tdm_partner_inst.rx_b[3] = 8'h3C;
    vcw(9'h007, '{base: 12'h100, depth: 9'h001, bonded: 1'h0,
      push: 1'h1});
    vcw(9'h008, '{base: 12'h200, depth: 9'h001, bonded: 1'h1,
      push: 1'h0});
    ext_wr(12'h200, 8'hA5);
    ext_wr(12'h201, 8'h5A);
    cmw(5'h03, '{from_en: 1'h1, from_vc: 1'h1, vc_id: 9'h007, default: '0});
    cmw(5'h06, '{to_en: 1'h1, to_vc: 1'h1, vc_id: 9'h008, default: '0});
    wait_frames(3);
    chk(push_id, 9'h007, "push channel wrap");
    chk(pull_id, 9'h008, "pull channel wrap");
    ext_rd(12'h100, got);
    chk({1'h0, got}, 9'h03C, "push window byte 0");
    ext_rd(12'h101, got);
    chk({1'h0, got}, 9'h03C, "push window byte 1");
    tx_a = svs_tdm_partner_inst.tx_b[6];
    wait_frames(1);
    got = svs_tdm_partner_inst.tx_b[6];
    chk({1'h0, tx_a ^ got}, 9'h0FF, "pull bytes alternate");
    $display("Test virtual channels done");
  endtask : t_vchan

  // One packed byte broadcast onto four slots, three pieces taken apart and the bonded one kept whole
  task automatic t_unpack;
    clr();
    subrate_en = 1'h1;
    ext_wr(12'h030, 8'h00);
    ext_wr(12'h031, 8'h00);
    ext_wr(12'h032, 8'h00);
    for (int s = 12; s < 16; s++) begin
      svs_tdm_partner_inst.rx_b[s] = 8'h6F;
    end
    vcw(9'h009, '{base: 12'h300, depth: 9'h000, bonded: 1'h1, push: 1'h1});
    cfg_from(5'h0C, 7'h70, 12'h030);
    cfg_from(5'h0D, 7'h18, 12'h031);
    cfg_from(5'h0E, 7'h33, 12'h032);
    cmw(5'h0F, '{from_en: 1'h1, from_vc: 1'h1, sub: 7'h33, vc_id: 9'h009,
      default: '0});
    cfg_to(5'h14, 12'h030);
    cfg_to(5'h15, 12'h031);
    cfg_to(5'h16, 12'h032);
    wait_frames(3);
    chk_slot(20, 8'h01, 1'h1);
    chk_slot(21, 8'h06, 1'h1);
    chk_slot(22, 8'h80, 1'h1);
    chk(push_id, 9'h009, "bonded push wrap");
    ext_rd(12'h300, got);
    chk({1'h0, got}, 9'h06F, "bonded keeps whole byte");
    $display("Test broadcast unpacking done");
  endtask : t_unpack

  // ==========================================
  // Main sequence
  initial begin
    reset = 1'h1;
    run = 1'h0;
    subrate_en = 1'h0;
    cm_we = 1'h0;
    cm_slot = '0;
    cm_wdata = '0;
    vc_we = 1'h0;
    vc_id = '0;
    vc_wdata = '0;
    ext_rd_req = 1'h0;
    ext_rd_addr = '0;
    ext_wr_en = 1'h0;
    ext_wr_addr = '0;
    ext_wr_data = '0;
    for (int s = 0; s < 32; s++) svs_tdm_partner_inst.rx_b[s] = 8'h00;
    repeat (16) @(negedge sys_clk);
    reset = 1'h0;
    run = 1'h1;
    t_byte();
    t_dibit();
    t_off();
    t_vchan();
    t_unpack();
    final_report();
  end
endmodule : testbench
`default_nettype wire
